// file: design/scss_consts.svh
// register offsets, field positions, reset values and codes of the clock select block
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH

// --------------------------------------------------------------
// register offsets in the special function register space
// --------------------------------------------------------------
`define SCSS_ADDR_SYS_SEL      8'h8F
`define SCSS_ADDR_EXT_CTRL     8'hB6

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SCSS_RST_SYS_SEL       8'h00
`define SCSS_RST_EXT_CTRL      8'h00

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define SCSS_SEL_CODE_LSB      0
`define SCSS_SEL_DIV_LSB       4
`define SCSS_EXT_RANGE_LSB     0
`define SCSS_EXT_MODE_LSB      4
`define SCSS_EXT_VALID_BIT     7

// --------------------------------------------------------------
// source select codes
// --------------------------------------------------------------
`define SCSS_CODE_HF           3'h0
`define SCSS_CODE_EXT          3'h1
`define SCSS_CODE_LF           3'h2
`define SCSS_CODE_PLL          3'h4

// --------------------------------------------------------------
// multiplexer input positions
// --------------------------------------------------------------
`define SCSS_IDX_HF            2'h0
`define SCSS_IDX_EXT           2'h1
`define SCSS_IDX_LF            2'h2
`define SCSS_IDX_PLL           2'h3

`endif

// file: design/scss_pkg.sv
// types shared by the clock select block
package scss_pkg;

  // glitch-free switch sequencing
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,  // running on current source
    SW_DROP = 2'b01,  // waiting for old source low to gate it off
    SW_PICK = 2'b10   // waiting for new source low to gate it on
  } scss_sw_state_e;

  // external oscillator mode codes
  typedef enum logic [2:0] {
    EXT_OFF0     = 3'b000,
    EXT_OFF1     = 3'b001,
    EXT_CMOS     = 3'b010,
    EXT_CMOS_D2  = 3'b011,
    EXT_RC       = 3'b100,
    EXT_CAP      = 3'b101,
    EXT_XTAL     = 3'b110,
    EXT_XTAL_D2  = 3'b111
  } scss_ext_mode_e;

  typedef logic [7:0] scss_byte_t;

endpackage

// file: design/scss_level_div.sv
// power-of-two divider of a sampled clock level
`timescale 1ns/1ps

module scss_level_div (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       lvl_in,    // sampled source level
  input  wire logic [1:0] shift,     // divide by 2**shift
  output logic            lvl_out    // divided level, registered
);

  logic       prev_r;   // last sample, for edge finding
  logic       prev_nxt;
  logic [2:0] cnt_r;    // rising edges since last toggle
  logic [2:0] cnt_nxt;
  logic       out_r;
  logic       out_nxt;
  logic [2:0] last;     // count at which the output toggles
  logic       rise;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    rise     = lvl_in & ~prev_r;
    prev_nxt = lvl_in;
    cnt_nxt  = cnt_r;
    out_nxt  = out_r;
    case (shift)
      2'h1:    last = 3'h0;
      2'h2:    last = 3'h1;
      default: last = 3'h3;
    endcase
    if (shift == 2'h0) begin
      // undivided: follow the input one cycle late
      out_nxt = lvl_in;
      cnt_nxt = 3'h0;
    end else if (rise) begin
      if (cnt_r >= last) begin
        // toggle on every 2**(shift-1) rising edges
        cnt_nxt = 3'h0;
        out_nxt = ~out_r;
      end else begin
        cnt_nxt = cnt_r + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
      cnt_r  <= 3'h0;
      out_r  <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      out_r  <= out_nxt;
    end
  end

  assign lvl_out = out_r;

endmodule

// file: design/scss_clk_switch.sv
// glitch-free source multiplexer working on sampled clock levels
`timescale 1ns/1ps

module scss_clk_switch #(
  parameter int N  = 4,
  parameter int IW = 2
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [N-1:0]  src,       // sampled source levels
  input  wire logic [IW-1:0] sel_idx,   // wanted source
  input  wire logic          sel_ok,    // wanted code is a real source
  output logic               clk_out,   // gated level, registered
  output logic               busy       // switch under way
);

  scss_pkg::scss_sw_state_e st_r;
  scss_pkg::scss_sw_state_e st_nxt;
  logic [IW-1:0] cur_r;     // source now feeding the output
  logic [IW-1:0] cur_nxt;
  logic [IW-1:0] pend_r;    // source to move to
  logic [IW-1:0] pend_nxt;
  logic          en_r;      // output gate
  logic          en_nxt;
  logic          out_r;
  logic          out_nxt;

  // --------------------------------------------------------------
  // switch sequencing
  // --------------------------------------------------------------
  // gates change only while the affected source is low, so the
  // output never shows a shortened high phase
  always_comb begin
    st_nxt   = st_r;
    cur_nxt  = cur_r;
    pend_nxt = pend_r;
    en_nxt   = en_r;
    case (st_r)
      scss_pkg::SW_IDLE: begin
        // reserved codes leave the running source alone
        if (sel_ok && (sel_idx != cur_r)) begin
          pend_nxt = sel_idx;
          st_nxt   = scss_pkg::SW_DROP;
        end
      end
      scss_pkg::SW_DROP: begin
        if (!src[cur_r]) begin
          en_nxt  = 1'b0;
          cur_nxt = pend_r;
          st_nxt  = scss_pkg::SW_PICK;
        end
      end
      scss_pkg::SW_PICK: begin
        if (!src[cur_r]) begin
          en_nxt = 1'b1;
          st_nxt = scss_pkg::SW_IDLE;
        end
      end
      default: begin
        st_nxt = scss_pkg::SW_IDLE;
        en_nxt = 1'b1;
      end
    endcase
    out_nxt = en_nxt & src[cur_nxt];
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r   <= scss_pkg::SW_IDLE;
      cur_r  <= '0;
      pend_r <= '0;
      en_r   <= 1'b1;
      out_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cur_r  <= cur_nxt;
      pend_r <= pend_nxt;
      en_r   <= en_nxt;
      out_r  <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign busy    = (st_r != scss_pkg::SW_IDLE);

endmodule

// file: design/scss_top.sv
// system clock source select and external oscillator control block
//
// What this block does
// - internal oscillator selectable at once, no wait
// - crystal-valid set by hardware once settled
// - pll lock flag set only when locked
// - external clock still feeds timers, counter array
// - live switching; software picks settled sources only
// - select code picks one of four sources
// - output divide field gives /1 /2 /4 /8
// - select bits 7:6 read zero, written zero
// - crystal-valid meaningful only in mode 11x
// - external mode field decodes eight modes, six of them driven
// - external control bit 3 reads zero, ignored
// - rc and capacitor modes need no start-up
// - crystal claims two pins, other driven modes one, off modes none
// - internal scale divides 8,4,2,1; reset /8
// - low-frequency divider divides 8,4,2,1
`timescale 1ns/1ps
`include "scss_consts.svh"

module scss_top (
  input  wire logic       CLK_SYS,           // 250 MHz block clock
  input  wire logic       RST_B,             // async reset, low active
  input  wire logic [7:0] SFR_ADDR,          // special function register address
  input  wire logic [7:0] SFR_WDATA,         // write data
  input  wire logic       SFR_WE,            // write strobe
  input  wire logic       SFR_RE,            // read strobe
  output logic      [7:0] SFR_RDATA,         // read data, one cycle after strobe
  input  wire logic [1:0] HF_INTERNAL_SCALE, // from the internal control register
  input  wire logic [1:0] LF_INTERNAL_DIVIDER, // from the low-frequency control register
  input  wire logic       HF_OSC_LVL,        // internal oscillator level
  input  wire logic       LF_OSC_LVL,        // low-frequency oscillator level
  input  wire logic       EXT_OSC_LVL,       // external oscillator level
  input  wire logic       PLL_OSC_LVL,       // pll output level
  input  wire logic       EXT_SETTLED,       // amplitude detector says stable
  input  wire logic       PLL_LOCKED,        // pll phase detector in lock
  output logic            SYSTEM_CLOCK_LVL,        // selected system clock level
  output logic            CLKOUT_LVL,        // divided clock for the port pin
  output logic            PERIPH_EXT_LVL,    // external clock for timers
  output logic            PLL_LOCK_FLAG,     // lock status
  output logic            EXT_DRIVE_EN,      // external drive circuit on
  output logic      [2:0] EXT_MODE,          // external mode to the analog drive
  output logic      [2:0] EXT_DRIVE_RANGE,   // drive range to the analog drive
  output logic            OSC_PIN_IN_CLAIM,  // input oscillator pin taken over
  output logic            OSC_PIN_OUT_CLAIM, // output oscillator pin taken over
  output logic            SWITCH_BUSY        // source change under way
);

  // --------------------------------------------------------------
  // register state
  // --------------------------------------------------------------
  logic [2:0] clock_source_code_r;     // stored select code
  logic [2:0] clock_source_code_nxt;
  logic [1:0] clock_output_divide_r;   // port pin divide code
  logic [1:0] clock_output_divide_nxt;
  logic [2:0] external_mode_code_r;    // external mode
  logic [2:0] external_mode_code_nxt;
  logic [2:0] external_drive_range_r;  // drive range
  logic [2:0] external_drive_range_nxt;
  logic       crystal_valid_flag_r;    // hardware valid flag
  logic       crystal_valid_flag_nxt;
  logic       pll_lock_flag_r;         // hardware lock flag
  logic       pll_lock_flag_nxt;
  scss_pkg::scss_byte_t rdata_r;       // read data holding register
  scss_pkg::scss_byte_t rdata_nxt;

  // --------------------------------------------------------------
  // derived values
  // --------------------------------------------------------------
  logic       ext_on;        // drive circuit enabled
  logic       ext_xtal;      // crystal or resonator mode
  logic       ext_halve;     // divide-by-two stage in use
  logic [1:0] hf_shift;      // internal scale as a shift
  logic [1:0] lf_shift;      // low-frequency divider as a shift
  logic [1:0] ext_shift;     // external halving as a shift
  logic [1:0] sel_idx;       // multiplexer position of select code
  logic       sel_ok;        // select code names a real source
  logic       hf_scaled;     // divided sources
  logic       lf_scaled;
  logic       ext_scaled;
  logic       ext_src;       // external source after drive gate
  logic       sys_lvl;       // switch output
  logic       sw_busy;
  logic       out_div_lvl;   // port pin clock
  logic [3:0] src_vec;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  // select and mode decode is on stored fields so a reserved write cannot
  // disturb a running source; the scale shifts decode the input ports directly
  always_comb begin
    // 00x is off, everything else drives the circuit
    ext_on    = (external_mode_code_r[2:1] != 2'h0);
    ext_xtal  = (external_mode_code_r[2:1] == 2'h3);
    ext_halve = (external_mode_code_r == scss_pkg::EXT_CMOS_D2) ||
                (external_mode_code_r == scss_pkg::EXT_XTAL_D2);
    ext_shift = {1'b0, ext_halve};
    // code 00 divides by 8 and 11 by 1, so shift is 3 minus code
    hf_shift  = 2'h3 - HF_INTERNAL_SCALE;
    lf_shift  = 2'h3 - LF_INTERNAL_DIVIDER;
    sel_ok    = 1'b1;
    case (clock_source_code_r)
      `SCSS_CODE_HF:  sel_idx = `SCSS_IDX_HF;
      `SCSS_CODE_EXT: sel_idx = `SCSS_IDX_EXT;
      `SCSS_CODE_LF:  sel_idx = `SCSS_IDX_LF;
      `SCSS_CODE_PLL: sel_idx = `SCSS_IDX_PLL;
      default: begin
        // reserved: keep whatever is running
        sel_idx = `SCSS_IDX_HF;
        sel_ok  = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // source conditioning
  // --------------------------------------------------------------
  // the scale code reset from outside is 00, so after reset the
  // internal oscillator reaches the switch divided by eight
  scss_level_div u_hf_div (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .lvl_in  (HF_OSC_LVL),
    .shift   (hf_shift),
    .lvl_out (hf_scaled)
  );

  scss_level_div u_lf_div (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .lvl_in  (LF_OSC_LVL),
    .shift   (lf_shift),
    .lvl_out (lf_scaled)
  );

  scss_level_div u_ext_div (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .lvl_in  (EXT_OSC_LVL),
    .shift   (ext_shift),
    .lvl_out (ext_scaled)
  );

  // rc and capacitor modes pass straight through with no wait on
  // the valid flag; for crystal, waiting is left to software
  assign ext_src = ext_on & ext_scaled;

  // the internal oscillator needs no ready gate: selecting it takes
  // effect on the next low phase without any settling wait
  assign src_vec = {PLL_OSC_LVL, lf_scaled, ext_src, hf_scaled};

  // --------------------------------------------------------------
  // glitch-free system clock multiplexer
  // --------------------------------------------------------------
  // switching happens live; the switch trusts that the new source
  // already toggles, a dead source held high would stall it in the pick phase
  scss_clk_switch #(
    .N  (4),
    .IW (2)
  ) u_switch (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .src     (src_vec),
    .sel_idx (sel_idx),
    .sel_ok  (sel_ok),
    .clk_out (sys_lvl),
    .busy    (sw_busy)
  );

  // --------------------------------------------------------------
  // clock output divider for the port pin
  // --------------------------------------------------------------
  // code 00 passes, 11 divides by eight
  scss_level_div u_out_div (
    .clk     (CLK_SYS),
    .rst_b   (RST_B),
    .lvl_in  (sys_lvl),
    .shift   (clock_output_divide_r),
    .lvl_out (out_div_lvl)
  );

  // --------------------------------------------------------------
  // register writes and hardware flags
  // --------------------------------------------------------------
  always_comb begin
    clock_source_code_nxt    = clock_source_code_r;
    clock_output_divide_nxt  = clock_output_divide_r;
    external_mode_code_nxt   = external_mode_code_r;
    external_drive_range_nxt = external_drive_range_r;
    if (SFR_WE && (SFR_ADDR == `SCSS_ADDR_SYS_SEL)) begin
      // bits 7:6 and 3 are not stored, so they read back zero
      clock_source_code_nxt   = SFR_WDATA[`SCSS_SEL_CODE_LSB +: 3];
      clock_output_divide_nxt = SFR_WDATA[`SCSS_SEL_DIV_LSB +: 2];
    end
    if (SFR_WE && (SFR_ADDR == `SCSS_ADDR_EXT_CTRL)) begin
      // bit 3 and the valid bit are dropped on write
      external_mode_code_nxt   = SFR_WDATA[`SCSS_EXT_MODE_LSB +: 3];
      external_drive_range_nxt = SFR_WDATA[`SCSS_EXT_RANGE_LSB +: 3];
    end
    // valid only means something in crystal modes, reads 0 elsewhere
    crystal_valid_flag_nxt = ext_xtal & EXT_SETTLED;
    // lock flag follows the loop detector, never set ahead of it
    pll_lock_flag_nxt      = PLL_LOCKED;
  end

  // --------------------------------------------------------------
  // register read
  // --------------------------------------------------------------
  // read data are held between strobes; unmapped offsets give zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (SFR_RE) begin
      case (SFR_ADDR)
        `SCSS_ADDR_SYS_SEL:
          rdata_nxt = {2'h0, clock_output_divide_r, 1'b0,
                       clock_source_code_r};
        `SCSS_ADDR_EXT_CTRL:
          rdata_nxt = {crystal_valid_flag_r, external_mode_code_r, 1'b0,
                       external_drive_range_r};
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      clock_source_code_r    <= 3'(`SCSS_RST_SYS_SEL);
      clock_output_divide_r  <= 2'h0;
      external_mode_code_r   <= 3'h0;
      external_drive_range_r <= 3'h0;
      crystal_valid_flag_r   <= 1'b0;
      pll_lock_flag_r        <= 1'b0;
      rdata_r                <= 8'h00;
    end else begin
      clock_source_code_r    <= clock_source_code_nxt;
      clock_output_divide_r  <= clock_output_divide_nxt;
      external_mode_code_r   <= external_mode_code_nxt;
      external_drive_range_r <= external_drive_range_nxt;
      crystal_valid_flag_r   <= crystal_valid_flag_nxt;
      pll_lock_flag_r        <= pll_lock_flag_nxt;
      rdata_r                <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------
  logic sys_lvl_r;       // registered system clock level
  logic clkout_r;        // registered port pin clock
  logic periph_ext_r;    // registered peripheral clock
  logic pin_in_r;        // input pin claim
  logic pin_out_r;       // output pin claim
  logic busy_r;
  logic sys_lvl_nxt;
  logic clkout_nxt;
  logic periph_ext_nxt;
  logic pin_in_nxt;
  logic pin_out_nxt;
  logic busy_nxt;

  always_comb begin
    sys_lvl_nxt    = sys_lvl;
    clkout_nxt     = out_div_lvl;
    // timers keep their external clock whatever drives the system
    periph_ext_nxt = ext_src;
    // crystal needs both pins, the single-pin modes only the output
    pin_in_nxt     = ext_xtal;
    pin_out_nxt    = ext_on;
    busy_nxt       = sw_busy;
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      sys_lvl_r    <= 1'b0;
      clkout_r     <= 1'b0;
      periph_ext_r <= 1'b0;
      pin_in_r     <= 1'b0;
      pin_out_r    <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      sys_lvl_r    <= sys_lvl_nxt;
      clkout_r     <= clkout_nxt;
      periph_ext_r <= periph_ext_nxt;
      pin_in_r     <= pin_in_nxt;
      pin_out_r    <= pin_out_nxt;
      busy_r       <= busy_nxt;
    end
  end

  // every output below is a flip-flop
  assign SFR_RDATA         = rdata_r;
  assign SYSTEM_CLOCK_LVL        = sys_lvl_r;
  assign CLKOUT_LVL        = clkout_r;
  assign PERIPH_EXT_LVL    = periph_ext_r;
  assign PLL_LOCK_FLAG     = pll_lock_flag_r;
  assign EXT_DRIVE_EN      = pin_out_r;
  assign EXT_MODE          = external_mode_code_r;
  assign EXT_DRIVE_RANGE   = external_drive_range_r;
  assign OSC_PIN_IN_CLAIM  = pin_in_r;
  assign OSC_PIN_OUT_CLAIM = pin_out_r;
  assign SWITCH_BUSY       = busy_r;

endmodule

// file: bench/scss_osc_model.sv
// oscillators and status detectors facing the clock select block
`timescale 1ns/1ps

module scss_osc_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       drive_en, // external drive on
  input  wire logic [2:0] mode,     // external mode
  output logic            hf_lvl,   // period 4 cycles
  output logic            lf_lvl,   // period 16 cycles
  output logic            ext_lvl,  // period 6 cycles while driven
  output logic            pll_lvl,  // period 2 cycles
  output logic            settled,  // crystal amplitude good
  output logic            locked    // pll in lock
);
  // --------------------------------------------------------------
  // sources and detectors
  // --------------------------------------------------------------
  logic [7:0] cnt_r; // free phase counter
  logic [1:0] ph_r;  // external toggle phase
  logic [7:0] xt_r;  // crystal settle timer
  assign hf_lvl  = cnt_r[1];
  assign lf_lvl  = cnt_r[3];
  assign pll_lvl = cnt_r[0];
  assign settled = (xt_r == 8'h64);
  // ext level still while drive off; rc and cap run at once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= 8'h00;
      ph_r    <= 2'h0;
      xt_r    <= 8'h00;
      ext_lvl <= 1'b0;
      locked  <= 1'b0;
    end else begin
      cnt_r  <= cnt_r + 8'h01;
      locked <= locked | (cnt_r == 8'h1F);
      ph_r   <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      if (drive_en && ph_r == 2'h2) begin
        ext_lvl <= ~ext_lvl;
      end
      if (mode[2:1] != 2'h3) begin // timer restarts outside crystal mode
        xt_r <= 8'h00;
      end else if (xt_r != 8'h64) begin
        xt_r <= xt_r + 8'h01;
      end
    end
  end
endmodule

// file: bench/scss_top_monitor.sv
// concurrent checks on the clock select ports
`timescale 1ns/1ps

module scss_top_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RST_B,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WE,
  input wire logic       SFR_RE,
  input wire logic [7:0] SFR_RDATA,
  input wire logic [2:0] EXT_MODE,
  input wire logic [2:0] EXT_DRIVE_RANGE,
  input wire logic       PLL_LOCKED,
  input wire logic       PLL_LOCK_FLAG,
  input wire logic       OSC_PIN_IN_CLAIM,
  input wire logic       OSC_PIN_OUT_CLAIM,
  input wire logic       SWITCH_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic rd_sel; // select register read
  logic rd_ext; // external control read
  logic rsv_wr; // reserved source code written
  assign rd_sel = SFR_RE && SFR_ADDR == 8'h8F;
  assign rd_ext = SFR_RE && SFR_ADDR == 8'hB6;
  assign rsv_wr = SFR_WE && SFR_ADDR == 8'h8F && SFR_WDATA[2:0] inside {3, 5, 6, 7};
  // --------------------------------------------------------------
  // switch sequence and flag, pin and register checks
  // --------------------------------------------------------------
  sequence s_sw_start;
    $rose(SWITCH_BUSY);
  endsequence
  sequence s_sw_end;
    ##[1:900] !SWITCH_BUSY;
  endsequence
  property p_sw_bound;
    s_sw_start |-> s_sw_end;
  endproperty
  property p_rsv;
    rsv_wr && !SWITCH_BUSY && !$past(SFR_WE) && !$past(SFR_WE, 2) |-> ##1 !SWITCH_BUSY [*4];
  endproperty
  property p_lock_on;
    PLL_LOCKED |=> PLL_LOCK_FLAG;
  endproperty
  property p_lock_off;
    !PLL_LOCKED |=> !PLL_LOCK_FLAG;
  endproperty
  property p_pin_in;
    OSC_PIN_IN_CLAIM == (&$past(EXT_MODE[2:1]));
  endproperty
  property p_pin_out;
    OSC_PIN_OUT_CLAIM == (|$past(EXT_MODE[2:1]));
  endproperty
  property p_ext_wr;
    SFR_WE && SFR_ADDR == 8'hB6 |=>
      EXT_MODE == $past(SFR_WDATA[6:4]) && EXT_DRIVE_RANGE == $past(SFR_WDATA[2:0]);
  endproperty
  property p_sel_rsv;
    rd_sel |=> SFR_RDATA[7:6] == 2'h0 && !SFR_RDATA[3];
  endproperty
  property p_ext_bit3;
    rd_ext |=> !SFR_RDATA[3];
  endproperty
  property p_valid_off;
    rd_ext && !(&EXT_MODE[2:1]) && !(&$past(EXT_MODE[2:1])) |=> !SFR_RDATA[7];
  endproperty
  a_sw_bound: assert property (p_sw_bound) else $error("switch never ended");
  a_rsv: assert property (p_rsv) else $error("reserved code switched");
  a_lock_on: assert property (p_lock_on) else $error("lock flag missing");
  a_lock_off: assert property (p_lock_off) else $error("lock flag early");
  a_pin_in: assert property (p_pin_in) else $error("input pin claim wrong");
  a_pin_out: assert property (p_pin_out) else $error("output pin claim wrong");
  a_ext_wr: assert property (p_ext_wr) else $error("external fields not stored");
  a_sel_rsv: assert property (p_sel_rsv) else $error("select reserved bits set");
  a_ext_bit3: assert property (p_ext_bit3) else $error("external bit 3 set");
  a_valid_off: assert property (p_valid_off) else $error("valid outside crystal");
endmodule

bind scss_top scss_top_monitor scss_top_monitor_inst (.*);

// file: bench/scss_tb.sv
// self-checking bench for the clock select block
`timescale 1ns/1ps

module testbench;
  logic CLK_SYS, SYSTEM_CLOCK_LVL, CLKOUT_LVL, PERIPH_EXT_LVL, PLL_LOCK_FLAG, EXT_DRIVE_EN;
  logic HF_OSC_LVL, LF_OSC_LVL, EXT_OSC_LVL, PLL_OSC_LVL, EXT_SETTLED, PLL_LOCKED;
  logic OSC_PIN_IN_CLAIM, OSC_PIN_OUT_CLAIM, SWITCH_BUSY, rd_pend;
  logic RST_B = 1'b0, SFR_WE = 1'b0, SFR_RE = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, t;
  logic [1:0] HF_INTERNAL_SCALE = 2'h0, LF_INTERNAL_DIVIDER = 2'h0;
  logic [2:0] EXT_MODE, EXT_DRIVE_RANGE;
  logic [15:0] lfsr = 16'h4847; // seed
  logic [7:0] exp_q[$];         // expected read data, oldest first
  int n_mismatch = 0, num_checks = 0, m;
  scss_top scss_top_inst (.*);
  scss_osc_model scss_osc_model_inst (.clk(CLK_SYS), .rst_b(RST_B), .drive_en(EXT_DRIVE_EN),
    .mode(EXT_MODE), .hf_lvl(HF_OSC_LVL), .lf_lvl(LF_OSC_LVL), .ext_lvl(EXT_OSC_LVL),
    .pll_lvl(PLL_OSC_LVL), .settled(EXT_SETTLED), .locked(PLL_LOCKED));
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK_SYS);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WE = 1'b1;
    @(negedge CLK_SYS);
    SFR_WE = 1'b0;
  endtask
  // strobe and expectation go out together
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CLK_SYS);
    SFR_ADDR = a;
    SFR_RE = 1'b1;
    exp_q.push_back(e);
    @(negedge CLK_SYS);
    SFR_RE = 1'b0;
  endtask
  // bounded wait for a source change
  task automatic wait_sw;
    int i;
    for (i = 0; i < 8 && SWITCH_BUSY !== 1'b1; i++) @(negedge CLK_SYS);
    check({7'h00, SWITCH_BUSY}, 8'h01);
    for (i = 0; i < 900 && SWITCH_BUSY !== 1'b0; i++) @(negedge CLK_SYS);
    if (SWITCH_BUSY !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  // level transitions over n cycles
  task automatic count_tg(input bit which, input int n, output logic [7:0] c);
    logic p, q;
    c = 8'h00;
    repeat (8) @(negedge CLK_SYS);
    p = which ? PERIPH_EXT_LVL : CLKOUT_LVL;
    repeat (n) begin
      @(negedge CLK_SYS);
      q = which ? PERIPH_EXT_LVL : CLKOUT_LVL;
      c += {7'h00, p ^ q};
      p = q;
    end
  endtask
  // read data land one edge after the strobe
  always @(posedge CLK_SYS) rd_pend <= SFR_RE;
  always @(negedge CLK_SYS) if (rd_pend && exp_q.size() > 0) check(SFR_RDATA, exp_q.pop_front());
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(negedge CLK_SYS);
    RST_B = 1'b1;
    rd(8'h8F, 8'h00);
    rd(8'hB6, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h37);
    wr(8'h8F, 8'h00);
    for (m = 0; m < 8; m++) begin
      lfsr = nxt(lfsr);
      wr(8'hB6, {1'b1, m[2:0], 1'b1, lfsr[2:0]});
      rd(8'hB6, {1'b0, m[2:0], 1'b0, lfsr[2:0]});
    end
    wr(8'hB6, 8'h67);
    repeat (120) @(negedge CLK_SYS);
    rd(8'hB6, 8'hE7);
    wr(8'h8F, 8'h01);
    wait_sw();
    wr(8'h8F, 8'h04);
    wait_sw();
    for (m = 0; m < 4; m++) begin
      wr(8'h8F, {2'h0, m[1:0], 4'h4});
      repeat (20) @(negedge CLK_SYS);
      count_tg(1'b0, 64, t);
      check(t, 8'h40 >> m);
    end
    count_tg(1'b1, 30, t);
    check(t, 8'h0A);
    wr(8'hB6, 8'h77);
    count_tg(1'b1, 30, t);
    check(t, 8'h05);
    lfsr = nxt(lfsr);
    LF_INTERNAL_DIVIDER = lfsr[3:2];
    HF_INTERNAL_SCALE = lfsr[1:0];
    wr(8'h8F, 8'h02);
    wait_sw();
    count_tg(1'b0, 128, t);
    check(t, 8'h02 << LF_INTERNAL_DIVIDER);
    wr(8'h8F, 8'h00);
    wait_sw();
    count_tg(1'b0, 64, t);
    check(t, 8'h04 << HF_INTERNAL_SCALE);
    print_verdict();
  end
endmodule
